//--- rtl/acdp_top.sv
// Auxiliary control register with dual data pointers and nonvolatile map
// How it works
// - Writing the control register with bit 3 set clears the select bit, reserved bit, both pointers, result and jump target, and restarts at address 0000.
// - Two pointers exist, bit 0 selects one and the other stays hidden until bit 0 changes.
// - Increment, indirect jump, 16-bit load, code read and data read all use the selected pointer only; data writes change nothing.
// - Reads and writes of the pointer low and high bytes reach the selected pointer.
// - Bit 2 of the control register reads zero and ignores writes.
// - Data moves through the pointer return the configuration bytes at their addresses.
// - The three signature bytes are returned by code reads at FC30h, FC31h and FC60h.
// - The customer area FCE0h to FCFFh is returned by code reads and programmed like program memory.
// - The customer area is served only as data through code reads, never as instructions.
// - In programming mode commands, addresses and data move serially over two pins.
// - The customer area is programmed in the same session as program memory and configuration bytes.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module acdp_top
  import acdp_pkg::*;
#(
  parameter logic [7:0] SIG0 = 8'h11, // Arbitrary value
  parameter logic [7:0] SIG1 = 8'h22, // Arbitrary value
  parameter logic [7:0] SIG2 = 8'h33  // Arbitrary value
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core reset request
  output logic soft_reset,
  output logic [15:0] restart_addr,
  // Serial programming pins
  input wire logic prog_mode,
  input wire logic prog_clk,
  input wire logic prog_din,
  output logic prog_dout,
  output logic prog_doe,
  // Main program memory write
  output logic main_wr,
  output logic [15:0] main_addr,
  output logic [7:0] main_data
);
  typedef enum logic [2:0] {
    PG_IDLE = 3'b001,
    PG_SHIFT = 3'b010,
    PG_SEND = 3'b100
  } acdp_pg_e;

  logic pready_q, pslverr_q, soft_reset_q, sel_q, rsv_q, clk_d_q, dout_q, doe_q, main_wr_q;
  logic [31:0] prdata_q;
  logic [15:0] restart_q, jump_q, main_addr_q;
  logic [7:0] result_q, trig_cnt_q, out_q, main_data_q;
  logic [2:0] sync1_q, sync2_q;
  acdp_pg_e pg_q;
  logic [4:0] cnt_q;
  logic [30:0] shreg_q;

  logic acc_first, acc_done, wr_done, addr_hit, trig_req, cmd_wr, mode_s, rise, frame_done, prog_we, prog_hit;
  logic [2:0] op;
  logic [7:0] acc_a, cpu_byte, prog_byte;
  logic [15:0] act_ptr, cpu_addr;
  logic [31:0] rd_d, frame_w;

  // ==========================================================
  // Bus phases and decode
  assign acc_first = psel & penable & ~pready_q;
  assign acc_done = psel & penable & pready_q;
  assign wr_done = acc_done & pwrite;
  assign addr_hit = paddr[1:0] == 2'b00 && paddr <= ACDP_STAT_OFF; // Seven aligned words from offset zero
  assign trig_req = wr_done & paddr == ACDP_AUX_OFF & pwdata[ACDP_TRIG_BIT];
  assign cmd_wr = wr_done & paddr == ACDP_CMD_OFF & ~trig_req;
  assign op = pwdata[2:0];
  assign acc_a = pwdata[15:8];

  // Pointer address for code reads is pointer plus offset
  assign cpu_addr = op == ACDP_OP_CODE ? act_ptr + {8'h00, acc_a} : act_ptr;

  // ==========================================================
  // Pointer bank
  acdp_ptr_bank u_ptrs (
    .clk(pclk),
    .rst_n(presetn),
    .soft_clr(trig_req),
    .sel(sel_q),
    .op_inc(cmd_wr & op == ACDP_OP_INC),
    .op_load(cmd_wr & op == ACDP_OP_LOAD),
    .load_val(pwdata[31:16]),
    .wr_lo(wr_done & paddr == ACDP_PLO_OFF),
    .wr_hi(wr_done & paddr == ACDP_PHI_OFF),
    .wr_byte(pwdata[7:0]),
    .act_ptr(act_ptr)
  );

  // Nonvolatile map
  acdp_nvm #(
    .SIG0(SIG0),
    .SIG1(SIG1),
    .SIG2(SIG2)
  ) u_nvm (
    .clk(pclk),
    .rst_n(presetn),
    .cpu_addr(cpu_addr),
    .cpu_code(op == ACDP_OP_CODE),
    .cpu_byte(cpu_byte),
    .prog_addr(frame_w[23:8]),
    .prog_we(prog_we),
    .prog_wdata(frame_w[7:0]),
    .prog_byte(prog_byte),
    .prog_hit(prog_hit)
  );

  // ==========================================================
  // Read data mux
  always_comb
  begin
    rd_d = 32'h0000_0000;
    case (paddr)
      ACDP_AUX_OFF: rd_d = {30'h0000_0000, rsv_q, sel_q};
      ACDP_PLO_OFF: rd_d = {24'h00_0000, act_ptr[7:0]};
      ACDP_PHI_OFF: rd_d = {24'h00_0000, act_ptr[15:8]};
      ACDP_PTR_OFF: rd_d = {16'h0000, act_ptr};
      ACDP_RES_OFF: rd_d = {jump_q, 8'h00, result_q};
      ACDP_STAT_OFF: rd_d = {16'h0000, trig_cnt_q, 7'h00, mode_s};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Bus answer: one wait state, then completion
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= acc_first;
      prdata_q <= acc_first && !pwrite ? rd_d : 32'h0000_0000;
      pslverr_q <= acc_first & ~addr_hit;
    end
  end

  // ==========================================================
  // Control register: select and reserved bit; trigger never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_q <= ACDP_AUX_RESET[ACDP_SEL_BIT];
      rsv_q <= ACDP_AUX_RESET[ACDP_RSV_BIT];
    end
    else if (trig_req)
    begin
      sel_q <= ACDP_AUX_RESET[ACDP_SEL_BIT];
      rsv_q <= ACDP_AUX_RESET[ACDP_RSV_BIT];
    end
    else if (wr_done && paddr == ACDP_AUX_OFF)
    begin
      sel_q <= pwdata[ACDP_SEL_BIT];
      rsv_q <= pwdata[ACDP_RSV_BIT];
    end
  end

  // Soft reset pulse, restart address and count
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_reset_q <= 1'b0;
      restart_q <= ACDP_RESTART_ADDR;
      trig_cnt_q <= 8'h00;
    end
    else
    begin
      soft_reset_q <= trig_req;
      restart_q <= ACDP_RESTART_ADDR;
      trig_cnt_q <= trig_cnt_q + {7'h00, trig_req};
    end
  end

  // ==========================================================
  // Pointer command results: code read, data read, jump target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q <= 8'h00;
      jump_q <= 16'h0000;
    end
    else if (trig_req)
    begin
      result_q <= 8'h00;
      jump_q <= 16'h0000;
    end
    else if (cmd_wr)
    begin
      case (op)
        ACDP_OP_CODE: result_q <= cpu_byte;
        ACDP_OP_DREAD: result_q <= cpu_byte;
        ACDP_OP_JUMP: jump_q <= act_ptr + {8'h00, acc_a};
        default: result_q <= result_q; // Data writes have no bus to reach
      endcase
    end
  end

  // ==========================================================
  // Pin synchronisers: mode, clock, data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      clk_d_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {prog_din, prog_clk, prog_mode};
      sync2_q <= sync1_q;
      clk_d_q <= sync2_q[1];
    end
  end

  assign mode_s = sync2_q[0];
  assign rise = sync2_q[1] & ~clk_d_q;
  assign frame_w = {shreg_q, sync2_q[2]};
  assign frame_done = mode_s && pg_q == PG_SHIFT && rise && cnt_q == ACDP_FRAME_LAST;
  assign prog_we = frame_done & frame_w[31:24] == ACDP_PCMD_WRITE & prog_hit;

  // ==========================================================
  // Serial programming engine over clock and data pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_q <= PG_IDLE;
      cnt_q <= 5'h00;
      shreg_q <= 31'h0000_0000;
      out_q <= 8'h00;
      dout_q <= 1'b0;
      doe_q <= 1'b0;
    end
    else if (!mode_s)
    begin
      pg_q <= PG_IDLE;
      cnt_q <= 5'h00;
      doe_q <= 1'b0;
    end
    else
    begin
      case (pg_q)
        PG_IDLE:
        begin
          pg_q <= PG_SHIFT;
          cnt_q <= 5'h00;
        end
        PG_SHIFT:
        begin
          if (rise)
          begin
            shreg_q <= frame_w[30:0];
            cnt_q <= cnt_q + 5'h01;
            if (frame_done && frame_w[31:24] == ACDP_PCMD_READ)
            begin
              pg_q <= PG_SEND;
              cnt_q <= 5'h00;
              out_q <= prog_byte;
              dout_q <= prog_byte[7];
              doe_q <= 1'b1;
            end
          end
        end
        PG_SEND:
        begin
          if (rise)
          begin
            out_q <= {out_q[6:0], 1'b0};
            dout_q <= out_q[6];
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == ACDP_BYTE_LAST)
            begin
              pg_q <= PG_SHIFT;
              cnt_q <= 5'h00;
              doe_q <= 1'b0;
            end
          end
        end
        default: pg_q <= PG_IDLE;
      endcase
    end
  end

  // Program memory writes leave as one-cycle strobes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_wr_q <= 1'b0;
      main_addr_q <= 16'h0000;
      main_data_q <= 8'h00;
    end
    else
    begin
      main_wr_q <= frame_done & frame_w[31:24] == ACDP_PCMD_WRITE & ~prog_hit;
      if (frame_done)
      begin
        main_addr_q <= frame_w[23:8];
        main_data_q <= frame_w[7:0];
      end
    end
  end

  // ==========================================================
  // Outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign soft_reset = soft_reset_q;
  assign restart_addr = restart_q;
  assign prog_dout = dout_q;
  assign prog_doe = doe_q;
  assign main_wr = main_wr_q;
  assign main_addr = main_addr_q;
  assign main_data = main_data_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  trig_pulse_a: assert property (trig_req |=> soft_reset && restart_addr == ACDP_RESTART_ADDR)
    else $error("soft reset not issued");
  trig_clear_a: assert property (trig_req |=> !sel_q && act_ptr == 16'h0000)
    else $error("state not cleared by soft reset");
  reset_once_a: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset repeated");
  sel_write_a: assert property (wr_done && paddr == ACDP_AUX_OFF && !pwdata[3] |=> sel_q == $past(pwdata[0]))
    else $error("select bit not written");
  zero_bits_a: assert property (acc_first && !pwrite && paddr == ACDP_AUX_OFF |=> prdata[3:2] == 2'b00)
    else $error("bit 2 or 3 read nonzero");
  ptr_inc_a: assert property (cmd_wr && op == ACDP_OP_INC |=> act_ptr == $past(act_ptr) + 16'h0001)
    else $error("pointer increment wrong");
  low_byte_a: assert property (wr_done && paddr == ACDP_PLO_OFF && !trig_req |=> act_ptr[7:0] == $past(pwdata[7:0]))
    else $error("low byte not written");
  sig_read_a: assert property (cmd_wr && op == ACDP_OP_CODE && cpu_addr == ACDP_SIG2_ADDR |=> result_q == SIG2)
    else $error("signature byte wrong");
  read_shift_a: assert property (frame_done && frame_w[31:24] == ACDP_PCMD_READ |=> prog_doe ##1 prog_doe)
    else $error("read byte not driven");

  trig_seen_c: cover property (trig_req ##1 soft_reset);
  prog_read_c: cover property (frame_done && frame_w[31:24] == ACDP_PCMD_READ);
  sel_flip_c: cover property (wr_done && paddr == ACDP_AUX_OFF ##2 sel_q);
  prog_write_c: cover property (prog_we);
endmodule

//--- rtl/acdp_pkg.sv
// Shared constants of the auxiliary control and dual pointer block
package acdp_pkg;
  // ==========================================================
  // Register offsets (byte addresses on the register bus)
  localparam logic [7:0] ACDP_AUX_OFF = 8'h00;
  localparam logic [7:0] ACDP_PLO_OFF = 8'h04;
  localparam logic [7:0] ACDP_PHI_OFF = 8'h08;
  localparam logic [7:0] ACDP_CMD_OFF = 8'h0C;
  localparam logic [7:0] ACDP_PTR_OFF = 8'h10;
  localparam logic [7:0] ACDP_RES_OFF = 8'h14;
  localparam logic [7:0] ACDP_STAT_OFF = 8'h18;
  // ==========================================================
  // Auxiliary control register fields and reset values
  localparam int ACDP_SEL_BIT = 0;
  localparam int ACDP_RSV_BIT = 1;
  localparam int ACDP_ZERO_BIT = 2;
  localparam int ACDP_TRIG_BIT = 3;
  localparam logic [7:0] ACDP_AUX_RESET = 8'h00;
  localparam logic [15:0] ACDP_RESTART_ADDR = 16'h0000;
  // ==========================================================
  // Pointer command codes
  localparam logic [2:0] ACDP_OP_INC = 3'h1;
  localparam logic [2:0] ACDP_OP_LOAD = 3'h2;
  localparam logic [2:0] ACDP_OP_CODE = 3'h3;
  localparam logic [2:0] ACDP_OP_DREAD = 3'h4;
  localparam logic [2:0] ACDP_OP_DWRITE = 3'h5;
  localparam logic [2:0] ACDP_OP_JUMP = 3'h6;
  // ==========================================================
  // Nonvolatile map
  localparam logic [15:0] ACDP_SIG0_ADDR = 16'hFC30;
  localparam logic [15:0] ACDP_SIG1_ADDR = 16'hFC31;
  localparam logic [15:0] ACDP_SIG2_ADDR = 16'hFC60;
  localparam logic [15:0] ACDP_CUST_FIRST = 16'hFCE0;
  localparam logic [15:0] ACDP_CUST_LAST = 16'hFCFF;
  localparam logic [15:0] ACDP_CFG0_ADDR = 16'hFD00;
  localparam logic [15:0] ACDP_CFG1_ADDR = 16'hFD01;
  localparam logic [7:0] ACDP_ERASED = 8'hFF;
  // ==========================================================
  // Serial programming
  localparam logic [7:0] ACDP_PCMD_WRITE = 8'h01;
  localparam logic [7:0] ACDP_PCMD_READ = 8'h02;
  localparam logic [4:0] ACDP_FRAME_LAST = 5'h1F;
  localparam logic [4:0] ACDP_BYTE_LAST = 5'h07;
endpackage

//--- rtl/acdp_data_pointer.sv
// Two data pointers, only the selected one visible
`timescale 1ns/10ps
module acdp_ptr_bank
  import acdp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic soft_clr,
  input wire logic sel,
  input wire logic op_inc,
  input wire logic op_load,
  input wire logic [15:0] load_val,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wr_byte,
  // Selected pointer
  output logic [15:0] act_ptr
);
  logic [15:0] ptr_q [2];

  // ==========================================================
  // One register per pointer; only the selected one changes, except that soft clear zeroes both
  for (genvar i = 0; i < 2; i++)
  begin : g_ptr
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        ptr_q[i] <= 16'h0000;
      else if (soft_clr)
        ptr_q[i] <= 16'h0000;
      else if (sel == i[0])
      begin
        if (op_load)
          ptr_q[i] <= load_val;
        else if (op_inc)
          ptr_q[i] <= ptr_q[i] + 16'h0001;
        else if (wr_lo)
          ptr_q[i][7:0] <= wr_byte;
        else if (wr_hi)
          ptr_q[i][15:8] <= wr_byte;
      end
    end
  end

  // Inactive pointer never reaches the outside
  assign act_ptr = sel ? ptr_q[1] : ptr_q[0];
endmodule

//--- rtl/acdp_nvm.sv
// Signature bytes, customer area and configuration bytes
`timescale 1ns/10ps
module acdp_nvm
  import acdp_pkg::*;
#(
  parameter logic [7:0] SIG0 = 8'h11, // Arbitrary value
  parameter logic [7:0] SIG1 = 8'h22, // Arbitrary value
  parameter logic [7:0] SIG2 = 8'h33  // Arbitrary value
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Processor read port
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_code,
  output logic [7:0] cpu_byte,
  // Programming port
  input wire logic [15:0] prog_addr,
  input wire logic prog_we,
  input wire logic [7:0] prog_wdata,
  output logic [7:0] prog_byte,
  output logic prog_hit
);
  logic [7:0] cust_q [32];
  logic [7:0] cfg_q [2];

  // ==========================================================
  // Code-space lookup: signatures and customer area only
  function automatic logic [7:0] code_look(input logic [15:0] a, input logic [7:0] c);
    logic [7:0] v;
    v = ACDP_ERASED;
    if (a == ACDP_SIG0_ADDR)
      v = SIG0;
    else if (a == ACDP_SIG1_ADDR)
      v = SIG1;
    else if (a == ACDP_SIG2_ADDR)
      v = SIG2;
    else if (a >= ACDP_CUST_FIRST && a <= ACDP_CUST_LAST)
      v = c;
    return v;
  endfunction

  // Data-space lookup: configuration bytes only
  function automatic logic [7:0] data_look(input logic [15:0] a);
    logic [7:0] v;
    v = ACDP_ERASED;
    if (a == ACDP_CFG0_ADDR)
      v = cfg_q[0];
    else if (a == ACDP_CFG1_ADDR)
      v = cfg_q[1];
    return v;
  endfunction

  // ==========================================================
  // Processor and programmer reads
  always_comb
  begin
    if (cpu_code)
      cpu_byte = code_look(cpu_addr, cust_q[cpu_addr[4:0]]);
    else
      cpu_byte = data_look(cpu_addr);
    prog_hit = (prog_addr >= ACDP_CUST_FIRST && prog_addr <= ACDP_CUST_LAST) ||
               prog_addr == ACDP_CFG0_ADDR || prog_addr == ACDP_CFG1_ADDR;
    if (prog_addr == ACDP_CFG0_ADDR || prog_addr == ACDP_CFG1_ADDR)
      prog_byte = data_look(prog_addr);
    else
      prog_byte = code_look(prog_addr, cust_q[prog_addr[4:0]]);
  end

  // ==========================================================
  // Writes come from the programmer only, erased value at reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 32; i++)
        cust_q[i] <= ACDP_ERASED;
      cfg_q[0] <= ACDP_ERASED;
      cfg_q[1] <= ACDP_ERASED;
    end
    else if (prog_we)
    begin
      if (prog_addr == ACDP_CFG0_ADDR)
        cfg_q[0] <= prog_wdata;
      else if (prog_addr == ACDP_CFG1_ADDR)
        cfg_q[1] <= prog_wdata;
      else if (prog_addr >= ACDP_CUST_FIRST && prog_addr <= ACDP_CUST_LAST)
        cust_q[prog_addr[4:0]] <= prog_wdata;
    end
  end
endmodule

//--- testbench/tb.sv
// Self-checking bench for the auxiliary control and dual pointer block
`timescale 1ns/10ps
module tb import acdp_pkg::*;;
  // ==========================================================
  // Signals and model state
  localparam logic [7:0] S0 = 8'h5A; // Arbitrary value
  localparam logic [7:0] S1 = 8'hC3; // Arbitrary value
  localparam logic [7:0] S2 = 8'h96; // Arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic soft_reset;
  logic [15:0] restart_addr;
  logic prog_mode = 1'b0;
  logic prog_clk = 1'b0;
  logic prog_din = 1'b0;
  logic prog_dout;
  logic prog_doe;
  logic main_wr;
  logic [15:0] main_addr;
  logic [7:0] main_data;
  int fails = 0;
  int checks = 0;
  int sr_n = 0;
  int mw_n = 0;
  logic [15:0] mw_a;
  logic [7:0] mw_d;
  logic [31:0] rd;
  logic er;
  logic [15:0] pa, pb, ja;
  logic [7:0] off, d1, d2;
  logic [15:0] ca [6] = '{16'hFC30, 16'hFC31, 16'hFC60, 16'hFCE0, 16'hFCFF, 16'hFC2F};
  logic [7:0] ce [6] = '{S0, S1, S2, 8'hFF, 8'hFF, 8'hFF};

  // ==========================================================
  // Design under test
  acdp_top #(.SIG0(S0), .SIG1(S1), .SIG2(S2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .soft_reset(soft_reset), .restart_addr(restart_addr), .prog_mode(prog_mode),
    .prog_clk(prog_clk), .prog_din(prog_din), .prog_dout(prog_dout), .prog_doe(prog_doe),
    .main_wr(main_wr), .main_addr(main_addr), .main_data(main_data));

  // Clock and watchdog
  initial forever #2.5 pclk = ~pclk;
  initial
  begin
    #200000;
    fails++;
    tally_and_finish();
  end

  // Pulse monitors for core reset and main memory writes
  always @(posedge pclk)
  begin
    if (soft_reset === 1'b1) sr_n++;
    if (main_wr === 1'b1)
    begin
      mw_n++;
      mw_a = main_addr;
      mw_d = main_data;
    end
  end

  // ==========================================================
  // Tasks
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends once pready is sampled high; only the watchdog ends a wait that pready never ends
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check_eq(rd, e);
  endtask

  task automatic cmd(input logic [2:0] o, input logic [7:0] a, input logic [15:0] im);
    apb(1'b1, ACDP_CMD_OFF, {im, a, 5'h00, o});
  endtask

  // Load pointer, run a read op, compare result byte
  task automatic byte_at(input logic [2:0] o, input logic [15:0] p, input logic [7:0] a, input logic [7:0] e);
    cmd(ACDP_OP_LOAD, 8'h00, p);
    cmd(o, a, 16'h0000);
    apb(1'b0, ACDP_RES_OFF, 32'h0);
    check_eq({24'h0, rd[7:0]}, {24'h0, e});
  endtask

  // One serial frame, MSB first, slow clock phases
  task automatic ser(input logic [31:0] f);
    for (int i = 31; i >= 0; i--)
    begin
      prog_din <= f[i];
      repeat (4) @(posedge pclk);
      prog_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      prog_clk <= 1'b0;
    end
    repeat (8) @(posedge pclk);
  endtask

  // Clock out one read byte, MSB first, while the pin is driven
  task automatic rd_ser(input logic [7:0] e);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 7; i >= 0; i--)
    begin
      b[i] = prog_dout;
      check_eq({31'h0, prog_doe}, 32'h1);
      prog_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      prog_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    check_eq({24'h0, b}, {24'h0, e});
    check_eq({31'h0, prog_doe}, 32'h0);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(22345));
    pa = 16'($urandom);
    pb = 16'($urandom);
    off = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ACDP_AUX_OFF, {24'h0, ACDP_AUX_RESET});
    apb(1'b1, ACDP_AUX_OFF, 32'h0000_0005);
    rdc(ACDP_AUX_OFF, 32'h1);
    // Byte writes reach pointer one, load reaches pointer zero
    apb(1'b1, ACDP_PLO_OFF, {24'h0, pa[7:0]});
    apb(1'b1, ACDP_PHI_OFF, {24'h0, pa[15:8]});
    apb(1'b1, ACDP_AUX_OFF, 32'h0);
    cmd(ACDP_OP_LOAD, 8'h00, pb);
    rdc(ACDP_PTR_OFF, {16'h0, pb});
    apb(1'b1, ACDP_AUX_OFF, 32'h1);
    rdc(ACDP_PTR_OFF, {16'h0, pa});
    rdc(ACDP_PLO_OFF, {24'h0, pa[7:0]});
    rdc(ACDP_PHI_OFF, {24'h0, pa[15:8]});
    // Increment wraps at the top of the range
    cmd(ACDP_OP_LOAD, 8'h00, 16'hFFFF);
    cmd(ACDP_OP_INC, 8'h00, 16'h0000);
    rdc(ACDP_PTR_OFF, 32'h0);
    apb(1'b1, ACDP_AUX_OFF, 32'h0);
    rdc(ACDP_PTR_OFF, {16'h0, pb});
    // Jump target is pointer plus offset
    cmd(ACDP_OP_JUMP, off, 16'h0000);
    ja = pb + {8'h00, off};
    apb(1'b0, ACDP_RES_OFF, 32'h0);
    check_eq({16'h0, rd[31:16]}, {16'h0, ja});
    // Code map: signatures, customer edges, a neighbour
    for (int i = 0; i < 6; i++) byte_at(ACDP_OP_CODE, ca[i], 8'h00, ce[i]);
    byte_at(ACDP_OP_CODE, 16'hFC2F, 8'h01, S0);
    byte_at(ACDP_OP_DREAD, ACDP_CFG0_ADDR, 8'h00, ACDP_ERASED);
    byte_at(ACDP_OP_DREAD, ACDP_CFG1_ADDR, 8'h00, ACDP_ERASED);
    // Data write has no bus to reach: result byte unchanged
    cmd(ACDP_OP_DWRITE, 8'h00, 16'h0000);
    apb(1'b0, ACDP_RES_OFF, 32'h0);
    check_eq({24'h0, rd[7:0]}, {24'h0, ACDP_ERASED});
    // Unmapped address is refused
    rdc(8'h1C, 32'h0);
    check_eq({31'h0, er}, 32'h1);
    // Serial programming: customer byte, then main memory
    prog_mode <= 1'b1;
    repeat (6) @(posedge pclk);
    rdc(ACDP_STAT_OFF, 32'h1);
    ser({ACDP_PCMD_WRITE, 16'hFCE5, d1});
    ser({ACDP_PCMD_WRITE, 16'h0123, d2});
    ser({ACDP_PCMD_WRITE, ACDP_CFG0_ADDR, d2});
    ser({ACDP_PCMD_READ, 16'hFCE5, 8'h00});
    rd_ser(d1);
    prog_mode <= 1'b0;
    check_eq(mw_n, 1);
    check_eq({8'h0, mw_a, mw_d}, {8'h0, 16'h0123, d2});
    byte_at(ACDP_OP_CODE, 16'hFCE5, 8'h00, d1);
    byte_at(ACDP_OP_DREAD, ACDP_CFG0_ADDR, 8'h00, d2);
    // Soft reset: one pulse, registers cleared, nonvolatile kept
    apb(1'b1, ACDP_AUX_OFF, 32'h0000_0009);
    repeat (3) @(posedge pclk);
    check_eq(sr_n, 1);
    check_eq({16'h0, restart_addr}, {16'h0, ACDP_RESTART_ADDR});
    rdc(ACDP_AUX_OFF, 32'h0);
    rdc(ACDP_PTR_OFF, 32'h0);
    apb(1'b1, ACDP_AUX_OFF, 32'h1);
    rdc(ACDP_PTR_OFF, 32'h0);
    rdc(ACDP_STAT_OFF, 32'h0000_0100);
    byte_at(ACDP_OP_CODE, 16'hFCE5, 8'h00, d1);
    tally_and_finish();
  end
endmodule
